/* design/bpmfc_params.svh */
`ifndef BPMFC_PARAMS_SVH
`define BPMFC_PARAMS_SVH
// Clock period in nanoseconds.
`define BPMFC_CLK_NS 10
// Ultrasonic interval limit in microseconds and its longest count in cycles.
`define BPMFC_USONIC_US 40
`define BPMFC_USONIC_CYC ((`BPMFC_USONIC_US * 1000) / `BPMFC_CLK_NS)
// Over-voltage qualify filter in microseconds and its least count in cycles.
`define BPMFC_OV_FILT_US 5
`define BPMFC_OV_FILT_CYC ((`BPMFC_OV_FILT_US * 1000 + `BPMFC_CLK_NS - 1) / `BPMFC_CLK_NS)
// Consecutive zero-crossing cycles before power-save entry.
`define BPMFC_PSAVE_ENTRY 4'h8
// Consecutive under-voltage cycles before shutdown.
`define BPMFC_UV_CYC 4'h8
// Soft-start preparation count after power-on reset.
`define BPMFC_SS_PREP_CYC 8'h40
// Break-before-make gap in cycles.
`define BPMFC_DEAD_CYC 2'h1
`endif

/* design/bpmfc_pkg.sv */
package bpmfc_pkg;
   // Asynchronous comparator flags, all active high.
   typedef struct packed {
      logic fbBelowRef;
      logic zeroCross;
      logic valleyLimit;
      logic switchNodeRise;
      logic fbAboveSmart;
      logic fbOverVolt;
      logic fbBelowPgLow;
      logic fbAbovePgRec;
      logic fbUnderVolt;
      logic onTimeDone;
      logic ssDone;
      logic biasAboveOn;
      logic biasBelowOff;
   } bpmfc_flags_t;

   // Three-level enable-select decoded outside: off, forced-continuous, power-save allowed.
   typedef enum logic [1:0] {
      BPMFC_EN_OFF,
      BPMFC_EN_FCM,
      BPMFC_ENABLE_POWERSAVE_SELECT
   } bpmfc_en_t;

   // Gate command bundle.
   typedef struct packed {
      logic highSide;
      logic highFast;
      logic lowSide;
      logic tristate;
   } bpmfc_gate_t;
endpackage

/* design/bpmfc_sync3.sv */
// Three-stage synchroniser; a change is accepted once stages two and three agree.
module bpmfc_sync3 (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic asyncIn,
   output logic syncOut
);
   logic s1;
   logic s2;
   logic s3;

   // Stage one feeds only stage two, so metastability never reaches the filter.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         syncOut <= 1'b0;
      end else if (clkEn) begin
         s1 <= asyncIn;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            syncOut <= s3;
         end
      end
   end
endmodule

/* design/bpmfc_buck_control.sv */
`include "bpmfc_params.svh"

// Notes on behaviour
// - In forced-continuous, low-side drives after on-time until feedback reaches threshold.
// - Feedback at 600 mV starts an on-time; one-shot end swaps to low side.
// - Ultrasonic mode forces low side when pulses are over 40 us apart.
// - Ultrasonic mode releases low side after on-time once current reaches zero.
// - Plain power-save enters after eight consecutive zero-crossing off-times.
// - In plain power-save, release low side on zero cross; idle until feedback low.
// - A cycle without zero crossing exits plain power-save and clears the count.
// - Feedback 10 % high disables power-save and drives low side until threshold.
// - Each high-side pulse starts slow, goes fast once switch node has risen.
// - Valley limit keeps low side on and blocks new on-time until clear.
// - Soft-start waits for lockout and enable; compares against scaled ramp meanwhile.
// - Soft-start ends once ramp reaches 1.5 V; then fixed reference is used.
// - Pre-bias start-up releases low side on negative current, never discharging output.
// - Power good falls at -10 % and recovers above -8 %.
// - Power good falls above +20 %, the over-voltage trip.
// - Power good is low while enable-select is low with bias present.
// - Over-voltage at 720 mV latches low side, stops switching until re-enable.
// - Over-voltage must persist 5 us before latching.
// - Eight cycles at or below 450 mV tristate both drives until re-enable.
// - Enable-select: off, float gives forced-continuous, high allows power-save.
// - Drives tristate until bias is above 3 V; below 2.4 V switching stops.
module bpmfc_buck_control (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire bpmfc_pkg::bpmfc_flags_t flagsAsync,
   input wire bpmfc_pkg::bpmfc_en_t enableSelect,
   input wire logic variantUltrasonic,
   output logic highSideDrive,
   output logic highSideFast,
   output logic lowSideDrive,
   output logic gateTristate,
   output logic powerGood,
   output logic overvoltageTrip,
   output logic undervoltageTrip,
   output logic powerSaveActive,
   output logic softStartActive,
   output logic oneShotStart
);
   localparam int FlagW = $bits(bpmfc_pkg::bpmfc_flags_t);
   localparam int UsCyc = `BPMFC_USONIC_CYC;
   localparam int OvCyc = `BPMFC_OV_FILT_CYC;

   typedef enum logic [2:0] {
      BPMFC_ST_OFF,
      BPMFC_ST_PREP,
      BPMFC_ST_LOW,
      BPMFC_ST_GAP_HI,
      BPMFC_ST_HIGH,
      BPMFC_ST_GAP_LO,
      BPMFC_ST_IDLE,
      BPMFC_ST_FAULT
   } bpmfc_state_t;

   bpmfc_pkg::bpmfc_flags_t flags;
   bpmfc_pkg::bpmfc_gate_t gate;
   bpmfc_pkg::bpmfc_en_t enPrev;
   bpmfc_state_t state;
   logic [7:0] prepCount;
   logic [1:0] gapCount;
   logic [15:0] intervalCount;
   logic [9:0] ovCount;
   logic [3:0] uvCount;
   logic [3:0] zcCount;
   logic zcSeen;
   logic ovLatched;
   logic uvLatched;
   logic psActive;
   logic smartHold;
   logic ssActive;
   logic pgState;
   logic usonicForce;
   logic biasOk;
   logic enabled;
   logic psAllowed;
   logic reEnable;
   logic triggerOn;
   logic lowRelease;

   // Every flag crosses into the clock domain through its own synchroniser.
   genvar gi;
   generate
      for (gi = 0; gi < FlagW; gi++) begin : g_sync
         bpmfc_sync3 u_sync (
            .clk(clk),
            .rst_b(rst_b),
            .clkEn(clkEn),
            .asyncIn(flagsAsync[gi]),
            .syncOut(flags[gi])
         );
      end
   endgenerate

   assign enabled = enableSelect != bpmfc_pkg::BPMFC_EN_OFF;
   assign psAllowed = enableSelect == bpmfc_pkg::BPMFC_ENABLE_POWERSAVE_SELECT && !smartHold;
   assign reEnable = enPrev == bpmfc_pkg::BPMFC_EN_OFF && enabled;
   // The one-shot only fires once the valley limit has cleared.
   assign triggerOn = flags.fbBelowRef && !flags.valleyLimit;
   assign usonicForce = variantUltrasonic && psAllowed && intervalCount >= 16'(UsCyc);

   // Low side may drop early in power-save or pre-bias start, never in valley limit.
   always_comb begin
      lowRelease = 1'b0;
      if (!flags.valleyLimit && flags.zeroCross && !smartHold) begin
         if (ssActive) begin
            lowRelease = 1'b1;
         end else if (psAllowed && variantUltrasonic && !usonicForce) begin
            lowRelease = 1'b1;
         end else if (psAllowed && !variantUltrasonic && psActive) begin
            lowRelease = 1'b1;
         end
      end
   end

   // Bias tracking and the enable edge history.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         biasOk <= 1'b0;
         enPrev <= bpmfc_pkg::BPMFC_EN_OFF;
      end else if (clkEn) begin
         enPrev <= enableSelect;
         if (flags.biasAboveOn) begin
            biasOk <= 1'b1;
         end else if (flags.biasBelowOff) begin
            biasOk <= 1'b0;
         end
      end
   end

   // Fault latches: cleared only by bias loss or an enable toggle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovCount <= '0;
         uvCount <= '0;
         ovLatched <= 1'b0;
         uvLatched <= 1'b0;
      end else if (clkEn) begin
         ovCount <= (flags.fbOverVolt && enabled) ? ovCount + 10'h001 : '0;
         if (flags.fbUnderVolt && state != BPMFC_ST_OFF && state != BPMFC_ST_PREP && !ssActive) begin
            uvCount <= (uvCount == `BPMFC_UV_CYC) ? uvCount : uvCount + 4'h1;
         end else begin
            uvCount <= '0;
         end
         if (!biasOk || reEnable) begin
            ovLatched <= 1'b0;
            uvLatched <= 1'b0;
         end else begin
            if (enabled && ovCount >= 10'(OvCyc - 1)) begin
               ovLatched <= 1'b1;
            end
            if (uvCount == `BPMFC_UV_CYC - 4'h1 && flags.fbUnderVolt) begin
               uvLatched <= 1'b1;
            end
         end
      end
   end

   // Soft-start is held active in the off and preparation states and runs until the ramp is done.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ssActive <= 1'b1;
      end else if (clkEn) begin
         if (state == BPMFC_ST_OFF || state == BPMFC_ST_PREP) begin
            ssActive <= 1'b1;
         end else if (flags.ssDone) begin
            ssActive <= 1'b0;
         end
      end
   end

   // Smart power-save: over-regulation forces the low side until feedback falls to the reference.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         smartHold <= 1'b0;
      end else if (clkEn) begin
         if (enableSelect == bpmfc_pkg::BPMFC_ENABLE_POWERSAVE_SELECT && flags.fbAboveSmart && !ssActive) begin
            smartHold <= 1'b1;
         end else if (flags.fbBelowRef || !enabled) begin
            smartHold <= 1'b0;
         end
      end
   end

   // Plain power-save entry count; zero crossing is sampled during each off-time.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zcSeen <= 1'b0;
         zcCount <= '0;
         psActive <= 1'b0;
      end else if (clkEn) begin
         if (!psAllowed || variantUltrasonic) begin
            zcSeen <= 1'b0;
            zcCount <= '0;
            psActive <= 1'b0;
         end else if (state == BPMFC_ST_HIGH) begin
            zcSeen <= 1'b0;
         end else if (flags.zeroCross) begin
            zcSeen <= 1'b1;
         end
         if (psAllowed && !variantUltrasonic && state == BPMFC_ST_GAP_HI) begin
            if (zcSeen) begin
               if (zcCount == `BPMFC_PSAVE_ENTRY - 4'h1) begin
                  psActive <= 1'b1;
               end else begin
                  zcCount <= zcCount + 4'h1;
               end
            end else begin
               zcCount <= '0;
               psActive <= 1'b0;
            end
         end
      end
   end

   // Ultrasonic interval timer restarts on each high-side pulse; it saturates at its limit.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         intervalCount <= '0;
      end else if (clkEn) begin
         if (state == BPMFC_ST_HIGH || !variantUltrasonic) begin
            intervalCount <= '0;
         end else if (intervalCount < 16'(UsCyc)) begin
            intervalCount <= intervalCount + 16'h0001;
         end
      end
   end

   // Main switching sequence with a dead cycle between the two drives.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= BPMFC_ST_OFF;
         prepCount <= '0;
         gapCount <= '0;
      end else if (clkEn) begin
         unique case (state)
            BPMFC_ST_OFF: begin
               prepCount <= '0;
               if (biasOk && enabled && !ovLatched && !uvLatched) begin
                  state <= BPMFC_ST_PREP;
               end
            end
            BPMFC_ST_PREP: begin
               prepCount <= prepCount + 8'h01;
               if (prepCount == `BPMFC_SS_PREP_CYC - 8'h01) begin
                  state <= BPMFC_ST_IDLE;
               end
            end
            BPMFC_ST_IDLE: begin
               if (smartHold || usonicForce) begin
                  state <= BPMFC_ST_LOW;
               end else if (triggerOn) begin
                  gapCount <= `BPMFC_DEAD_CYC;
                  state <= BPMFC_ST_GAP_HI;
               end
            end
            BPMFC_ST_LOW: begin
               if (flags.valleyLimit) begin
                  state <= BPMFC_ST_LOW;
               end else if (triggerOn) begin
                  gapCount <= `BPMFC_DEAD_CYC;
                  state <= BPMFC_ST_GAP_HI;
               end else if (lowRelease) begin
                  state <= BPMFC_ST_IDLE;
               end
            end
            BPMFC_ST_GAP_HI: begin
               gapCount <= gapCount - 2'h1;
               if (gapCount == 2'h1) begin
                  state <= BPMFC_ST_HIGH;
               end
            end
            BPMFC_ST_HIGH: begin
               if (flags.onTimeDone) begin
                  gapCount <= `BPMFC_DEAD_CYC;
                  state <= BPMFC_ST_GAP_LO;
               end
            end
            BPMFC_ST_GAP_LO: begin
               gapCount <= gapCount - 2'h1;
               if (gapCount == 2'h1) begin
                  state <= BPMFC_ST_LOW;
               end
            end
            BPMFC_ST_FAULT: begin
               if (!ovLatched && !uvLatched) begin
                  state <= BPMFC_ST_OFF;
               end
            end
         endcase
         if (ovLatched || uvLatched) begin
            state <= BPMFC_ST_FAULT;
         end else if (!biasOk || !enabled) begin
            state <= BPMFC_ST_OFF;
         end
      end
   end

   // Gate command from the sequence; over-voltage holds the low side, under-voltage tristates.
   always_comb begin
      gate = '0;
      unique case (state)
         BPMFC_ST_HIGH: gate.highSide = 1'b1;
         BPMFC_ST_LOW: gate.lowSide = 1'b1;
         BPMFC_ST_OFF: gate.tristate = !biasOk || !enabled;
         BPMFC_ST_PREP: gate.tristate = 1'b1;
         BPMFC_ST_FAULT: begin
            gate.lowSide = ovLatched;
            gate.tristate = uvLatched && !ovLatched;
         end
         default: gate = '0;
      endcase
      gate.highFast = gate.highSide && flags.switchNodeRise;
   end

   // Power good hysteresis between the -10 % and -8 % windows.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pgState <= 1'b0;
      end else if (clkEn) begin
         if (flags.fbBelowPgLow || ssActive) begin
            pgState <= 1'b0;
         end else if (flags.fbAbovePgRec) begin
            pgState <= 1'b1;
         end
      end
   end

   // All outputs are registered so the gate drivers never see a decode glitch.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         highSideDrive <= 1'b0;
         highSideFast <= 1'b0;
         lowSideDrive <= 1'b0;
         gateTristate <= 1'b1;
         powerGood <= 1'b0;
         overvoltageTrip <= 1'b0;
         undervoltageTrip <= 1'b0;
         powerSaveActive <= 1'b0;
         softStartActive <= 1'b1;
         oneShotStart <= 1'b0;
      end else if (clkEn) begin
         highSideDrive <= gate.highSide && !lowSideDrive;
         highSideFast <= gate.highFast && !lowSideDrive;
         lowSideDrive <= gate.lowSide && !highSideDrive;
         gateTristate <= gate.tristate;
         powerGood <= pgState && enabled && biasOk && !ovLatched && !uvLatched
            && !flags.fbOverVolt && state != BPMFC_ST_OFF;
         overvoltageTrip <= ovLatched;
         undervoltageTrip <= uvLatched;
         powerSaveActive <= psActive || (variantUltrasonic && psAllowed);
         softStartActive <= ssActive;
         oneShotStart <= state == BPMFC_ST_GAP_HI && gapCount == 2'h1;
      end
   end
endmodule

/* verification/bpmfc_partner.sv */
// Behavioural power stage: gate drivers, switch node, one-shot and comparators.
module bpmfc_partner (
   input wire logic clk,
   input wire logic hs,
   input wire logic ls,
   input wire logic zcEn,
   input wire logic fbHold,
   output logic fbBelowRef,
   output logic swRise,
   output logic onDone,
   output logic zeroCross
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] hsCnt = 8'h00;
   logic [7:0] offCnt = 8'h00;
   // Time the on-time and the off-time; the off counter saturates so it never wraps.
   always @(posedge clk) begin
      hsCnt <= hs ? hsCnt + 8'h01 : 8'h00;
      offCnt <= hs ? 8'h00 : (offCnt == 8'hff ? offCnt : offCnt + 8'h01);
   end
   // The one-shot ends after twenty cycles of high side.
   assign onDone = (hsCnt >= 8'h14);
   // The switch node needs a few cycles to rise after turn-on.
   assign swRise = (hsCnt >= 8'h03);
   // Inductor current crosses zero late in the off-time at light load; it is sensed across the low side.
   assign zeroCross = zcEn && ls && (offCnt >= 8'h0f);
   // Feedback droops to the threshold some time after the high side ends.
   assign fbBelowRef = !fbHold && !hs && (offCnt >= 8'h1e);
endmodule

/* verification/bpmfc_buck_control_sva.sv */
// Port-level checks of the control core.
module bpmfc_buck_control_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire bpmfc_pkg::bpmfc_flags_t flagsAsync,
   input wire bpmfc_pkg::bpmfc_en_t enableSelect,
   input wire logic highSideDrive,
   input wire logic highSideFast,
   input wire logic lowSideDrive,
   input wire logic gateTristate,
   input wire logic powerGood,
   input wire logic overvoltageTrip,
   input wire logic undervoltageTrip,
   input wire logic oneShotStart
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic [9:0] ovCnt;
   logic [3:0] uvCnt;
   // Raw persistence counters; the synchroniser only adds delay, so raw counts bound the filter.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovCnt <= 10'h000;
      end else begin
         ovCnt <= !flagsAsync.fbOverVolt ? 10'h000 : (ovCnt == 10'h3ff ? ovCnt : ovCnt + 10'h001);
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         uvCnt <= 4'h0;
      end else begin
         uvCnt <= !flagsAsync.fbUnderVolt ? 4'h0 : (uvCnt == 4'hf ? uvCnt : uvCnt + 4'h1);
      end
   end
   no_overlap_a: assert property (!(highSideDrive && lowSideDrive)) else $error("drives overlap");
   fast_needs_high_a: assert property (highSideFast |-> highSideDrive) else $error("fast without high");
   slow_first_a: assert property ($rose(highSideDrive) |-> !highSideFast) else $error("no slow phase");
   oneshot_leads_a: assert property ($rose(highSideDrive) |-> $past(oneShotStart)) else $error("no one-shot");
   // A trip that cuts a high pulse short still owes the low side its dead cycle, so allow two cycles.
   ov_latch_a: assert property (overvoltageTrip && $past(overvoltageTrip, 2) |->
      lowSideDrive && !highSideDrive && !powerGood) else $error("bad drives after over-voltage");
   ov_filter_a: assert property ($rose(overvoltageTrip) |-> ovCnt >= 10'h1f4) else $error("short ov");
   uv_off_a: assert property (undervoltageTrip && $past(undervoltageTrip) |->
      gateTristate && !lowSideDrive && !highSideDrive) else $error("bad drives after under-voltage");
   uv_count_a: assert property ($rose(undervoltageTrip) |-> uvCnt >= 4'h8) else $error("short uv");
   pg_off_a: assert property ((enableSelect == bpmfc_pkg::BPMFC_EN_OFF) [*3] |-> !powerGood)
      else $error("power good while off");
   valley_block_a: assert property (flagsAsync.valleyLimit [*8] |-> !oneShotStart)
      else $error("on-time during limit");
endmodule

/* verification/bpmfc_buck_control_tb_top.sv */
module bpmfc_buck_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GT = 8, HS = 7, LS = 6, HF = 5, PG = 4, PS = 3, OV = 2, UV = 1, SS = 0;
   logic clk, rst_b, ultra, zcEn, fbHold, valley, smart, ov, pgLow, pgRec, uv, ssDone, biasOn, biasOff;
   logic pFb, pSw, pDone, pZc;
   logic highSideDrive, highSideFast, lowSideDrive, gateTristate, powerGood;
   logic overvoltageTrip, undervoltageTrip, powerSaveActive, softStartActive, oneShotStart;
   bpmfc_pkg::bpmfc_en_t enSel;
   bpmfc_pkg::bpmfc_flags_t flags;
   logic [8:0] obs;
   int error_cnt = 0;
   int n_tests = 0;
   realtime t0;
   assign flags = {pFb, pZc, valley, pSw, smart, ov, pgLow, pgRec, uv, pDone, ssDone, biasOn, biasOff};
   assign obs = {gateTristate, highSideDrive, lowSideDrive, highSideFast, powerGood, powerSaveActive,
      overvoltageTrip, undervoltageTrip, softStartActive};
   // The clock runs free; stimulus moves 1 ns after each rising edge.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   bpmfc_buck_control DUT (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .flagsAsync(flags),
      .enableSelect(enSel), .variantUltrasonic(ultra), .highSideDrive(highSideDrive),
      .highSideFast(highSideFast), .lowSideDrive(lowSideDrive), .gateTristate(gateTristate),
      .powerGood(powerGood), .overvoltageTrip(overvoltageTrip), .undervoltageTrip(undervoltageTrip),
      .powerSaveActive(powerSaveActive), .softStartActive(softStartActive), .oneShotStart(oneShotStart));
   bpmfc_partner u_stage (.clk(clk), .hs(highSideDrive), .ls(lowSideDrive), .zcEn(zcEn), .fbHold(fbHold),
      .fbBelowRef(pFb), .swRise(pSw), .onDone(pDone), .zeroCross(pZc));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   // Waits a bounded number of cycles for one watched output, then compares it.
   task automatic wt(input int b, input logic v, input int lim);
      int i;
      i = 0;
      while (obs[b] !== v && i < lim) begin
         step(1);
         i++;
      end
      chk(obs[b], v);
   endtask
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Full restart: reset for six cycles, bias appears late so the lockout can be seen.
   // The ramp is held unfinished for one pulse so the pre-bias low-side release is exercised.
   task automatic start_up(input logic u);
      {rst_b, zcEn, fbHold, valley, smart, ov, pgLow, pgRec, uv, biasOn, biasOff, ssDone} = '0;
      ultra = u;
      enSel = bpmfc_pkg::BPMFC_EN_FCM;
      step(6);
      wt(GT, 1'b1, 0);
      wt(SS, 1'b1, 0);
      rst_b = 1'b1;
      step(20);
      wt(GT, 1'b1, 0);
      wt(HS, 1'b0, 0);
      biasOn = 1'b1;
      wt(HS, 1'b1, 300);
      wt(SS, 1'b1, 0);
      zcEn = 1'b1;
      wt(LS, 1'b1, 40);
      wt(LS, 1'b0, 40);
      zcEn = 1'b0;
      ssDone = 1'b1;
      wt(SS, 1'b0, 300);
   endtask
   // The tests take roughly seven thousand cycles; the limit leaves a wide margin.
   initial begin
      #500000;
      error_cnt++;
      final_report();
   end
   initial begin
      start_up(1'b0);
      wt(HS, 1'b1, 200);
      wt(HF, 1'b1, 30);
      wt(HS, 1'b0, 40);
      wt(LS, 1'b1, 4);
      step(20);
      wt(LS, 1'b1, 0);
      pgRec = 1'b1;
      wt(PG, 1'b1, 20);
      pgLow = 1'b1;
      pgRec = 1'b0;
      wt(PG, 1'b0, 20);
      pgLow = 1'b0;
      step(30);
      wt(PG, 1'b0, 0);
      pgRec = 1'b1;
      wt(PG, 1'b1, 20);
      enSel = bpmfc_pkg::BPMFC_EN_OFF;
      wt(PG, 1'b0, 10);
      enSel = bpmfc_pkg::BPMFC_EN_FCM;
      wt(SS, 1'b1, 10);
      wt(SS, 1'b0, 300);
      valley = 1'b1;
      step(10);
      wt(LS, 1'b1, 60);
      step(200);
      wt(LS, 1'b1, 0);
      wt(HS, 1'b0, 0);
      valley = 1'b0;
      wt(HS, 1'b1, 100);
      enSel = bpmfc_pkg::BPMFC_ENABLE_POWERSAVE_SELECT;
      zcEn = 1'b1;
      wt(PS, 1'b1, 2000);
      wt(HS, 1'b1, 200);
      wt(HS, 1'b0, 40);
      wt(LS, 1'b1, 4);
      wt(LS, 1'b0, 30);
      zcEn = 1'b0;
      wt(PS, 1'b0, 500);
      zcEn = 1'b1;
      wt(PS, 1'b1, 2000);
      smart = 1'b1;
      fbHold = 1'b1;
      wt(PS, 1'b0, 60);
      wt(LS, 1'b1, 60);
      smart = 1'b0;
      fbHold = 1'b0;
      wt(HS, 1'b1, 100);
      wt(PG, 1'b1, 0);
      ov = 1'b1;
      step(300);
      wt(PG, 1'b0, 0);
      ov = 1'b0;
      step(10);
      wt(OV, 1'b0, 0);
      ov = 1'b1;
      wt(OV, 1'b1, 520);
      step(3);
      wt(LS, 1'b1, 0);
      wt(PG, 1'b0, 0);
      ov = 1'b0;
      enSel = bpmfc_pkg::BPMFC_EN_OFF;
      step(3);
      enSel = bpmfc_pkg::BPMFC_EN_FCM;
      wt(OV, 1'b0, 10);
      wt(SS, 1'b1, 10);
      wt(SS, 1'b0, 300);
      uv = 1'b1;
      step(6);
      uv = 1'b0;
      step(10);
      wt(UV, 1'b0, 0);
      uv = 1'b1;
      wt(UV, 1'b1, 20);
      step(2);
      wt(GT, 1'b1, 0);
      wt(LS, 1'b0, 0);
      start_up(1'b1);
      enSel = bpmfc_pkg::BPMFC_ENABLE_POWERSAVE_SELECT;
      zcEn = 1'b1;
      wt(HS, 1'b0, 40);
      wt(HS, 1'b1, 300);
      t0 = $realtime;
      fbHold = 1'b1;
      wt(HS, 1'b0, 40);
      wt(LS, 1'b1, 4);
      wt(LS, 1'b0, 40);
      wt(LS, 1'b1, 4200);
      chk(($realtime - t0) >= 39800.0 && ($realtime - t0) <= 40600.0, 1'b1);
      biasOn = 1'b0;
      biasOff = 1'b1;
      wt(GT, 1'b1, 10);
      wt(LS, 1'b0, 0);
      final_report();
   end
endmodule
bind bpmfc_buck_control bpmfc_buck_control_sva u_sva (.clk(clk), .rst_b(rst_b), .flagsAsync(flagsAsync),
   .enableSelect(enableSelect), .highSideDrive(highSideDrive), .highSideFast(highSideFast),
   .lowSideDrive(lowSideDrive), .gateTristate(gateTristate), .powerGood(powerGood),
   .overvoltageTrip(overvoltageTrip), .undervoltageTrip(undervoltageTrip), .oneShotStart(oneShotStart));
